/* File: src/ccs_calendar_clock.sv */
// calendar clock with change pulses, status flags and an APB register slave
`timescale 1ns/1ns
`include "ccs_defs.svh"

module ccs_calendar_clock #(
    parameter int unsigned TICKS_PER_SEC = `CCS_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire ccs_pkg::ccs_addr_t paddr,
    input wire ccs_pkg::ccs_word_t pwdata,
    output ccs_pkg::ccs_word_t prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic extPowerOk,
    input wire logic batteryDead,
    input wire logic oscRunning
);
    import ccs_pkg::*;

    // ****************************************
    // helpers
    // ****************************************

    // month length, leap every fourth year of the two-digit century
    function automatic logic [4:0] daysInMonth(input logic [3:0] m, input logic [6:0] y);
        logic [4:0] n;
        n = 5'h1F;
        case (m)
            4'h2: n = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            4'h4, 4'h6, 4'h9, 4'hB: n = 5'h1E;
            default: n = 5'h1F;
        endcase
        return n;
    endfunction : daysInMonth

    // true while every calendar field holds a legal value
    function automatic logic fieldsValid(input ccs_state_s s);
        logic ok;
        ok = 1'b1;
        if (s.day < `CCS_DAY_MIN || s.day > daysInMonth(s.month, s.year)) begin
            ok = 1'b0;
        end
        if (s.month < `CCS_MONTH_MIN || s.month > `CCS_MONTH_MAX) begin
            ok = 1'b0;
        end
        if (s.year > `CCS_YEAR_MAX) begin
            ok = 1'b0;
        end
        if (s.hour > `CCS_HOUR_MAX) begin
            ok = 1'b0;
        end
        if (s.minute > `CCS_MIN_MAX || s.sec > `CCS_SEC_MAX) begin
            ok = 1'b0;
        end
        if (s.wday < `CCS_WDAY_MIN) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : fieldsValid

    localparam logic [24:0] TickLast = 25'(TICKS_PER_SEC - 1);

    ccs_state_s st_q;
    ccs_state_s st_d;
    logic apbDone;
    logic wrDone;
    logic rdDone;
    logic fail;
    logic tick;
    logic load;
    logic [7:0] events;
    logic [7:0] rdClear;

    // ****************************************
    // next state
    // ****************************************

    // one process computes the whole next state; the bus, the count and the flags share it
    always_comb begin
        st_d = st_q;
        events = 8'h00;
        rdClear = 8'h00;
        apbDone = psel && penable && st_q.pready;
        wrDone = apbDone && pwrite;
        rdDone = apbDone && !pwrite;

        // the oscillator alone or a dead battery without mains stops the count
        fail = !oscRunning || (!extPowerOk && batteryDead);
        tick = 1'b0;
        if (!fail) begin
            if (st_q.tickCnt >= TickLast) begin
                st_d.tickCnt = 25'h0000000;
                tick = 1'b1;
            end else begin
                st_d.tickCnt = st_q.tickCnt + 25'h0000001;
            end
        end
        st_d.clockFail = fail;

        // staging words and mask take ordinary writes; the time words never do
        if (wrDone) begin
            case (paddr)
                `CCS_MASK_OFS: st_d.mask = pwdata[7:0];
                `CCS_STDATE_OFS: st_d.stageDate = pwdata;
                `CCS_STTIME_OFS: st_d.stageTime = pwdata;
                default: st_d.mask = st_q.mask;
            endcase
        end
        load = wrDone && (paddr == `CCS_CMD_OFS) && pwdata[`CCS_CMD_LOAD_BIT];

        // set-calendar copies the staged fields; it wins over a tick and restarts the second
        if (load) begin
            st_d.day = st_q.stageDate[`CCS_ST_DAY_LSB +: 5];
            st_d.month = st_q.stageDate[`CCS_ST_MONTH_LSB +: 4];
            st_d.year = st_q.stageDate[`CCS_ST_YEAR_LSB +: 7];
            st_d.wday = st_q.stageDate[`CCS_ST_WDAY_LSB +: 3];
            st_d.sec = st_q.stageTime[`CCS_ST_SEC_LSB +: 6];
            st_d.minute = st_q.stageTime[`CCS_ST_MIN_LSB +: 6];
            st_d.hour = st_q.stageTime[`CCS_ST_HOUR_LSB +: 5];
            st_d.tickCnt = 25'h0000000;
        end else if (tick) begin
            // ripple carry; >= lets an out-of-range field wrap instead of running away
            if (st_q.sec >= `CCS_SEC_MAX) begin
                st_d.sec = 6'h00;
                if (st_q.minute >= `CCS_MIN_MAX) begin
                    st_d.minute = 6'h00;
                    if (st_q.hour >= `CCS_HOUR_MAX) begin
                        st_d.hour = 5'h00;
                        st_d.wday = (st_q.wday >= `CCS_WDAY_MAX) ? `CCS_WDAY_MIN : st_q.wday + 3'h1;
                        if (st_q.day >= daysInMonth(st_q.month, st_q.year)) begin
                            st_d.day = `CCS_DAY_MIN;
                            if (st_q.month >= `CCS_MONTH_MAX) begin
                                st_d.month = `CCS_MONTH_MIN;
                                st_d.year = (st_q.year >= `CCS_YEAR_MAX) ? 7'h00 : st_q.year + 7'h01;
                            end else begin
                                st_d.month = st_q.month + 4'h1;
                            end
                        end else begin
                            st_d.day = st_q.day + 5'h01;
                        end
                    end else begin
                        st_d.hour = st_q.hour + 5'h01;
                    end
                end else begin
                    st_d.minute = st_q.minute + 6'h01;
                end
            end else begin
                st_d.sec = st_q.sec + 6'h01;
            end
        end

        // change bits compare new and old, so they last exactly one cycle
        st_d.live[`CCS_MIN_CHG_BIT] = st_d.minute != st_q.minute;
        st_d.live[`CCS_HOUR_CHG_BIT] = st_d.hour != st_q.hour;
        st_d.live[`CCS_DATE_CHG_BIT] = st_d.day != st_q.day;
        st_d.live[`CCS_MONTH_CHG_BIT] = st_d.month != st_q.month;
        st_d.live[`CCS_YEAR_CHG_BIT] = st_d.year != st_q.year;
        st_d.live[`CCS_BATT_BIT] = batteryDead;
        st_d.live[`CCS_INVALID_BIT] = !fieldsValid(st_d);

        // sticky copies for the interrupt; a rising fail is an event too
        events[6:0] = st_d.live;
        events[`CCS_CLK_FAIL_EV_BIT] = fail && !st_q.clockFail;

        // a read clears only what it returned, and a new event in that cycle survives
        if (rdDone && paddr == `CCS_EVT_OFS) begin
            rdClear = st_q.prdata[7:0];
        end
        st_d.evStat = (st_q.evStat & ~rdClear) | events;
        st_d.irq = |(st_d.evStat & st_d.mask);

        // read data is prepared in the setup cycle, so the access phase never waits
        st_d.pready = 1'b0;
        st_d.pslverr = 1'b0;
        if (psel && !penable) begin
            st_d.pready = 1'b1;
            st_d.prdata = 32'h00000000;
            case (paddr)
                `CCS_DAY_OFS: st_d.prdata = {27'h0000000, st_q.day};
                `CCS_MONTH_OFS: st_d.prdata = {28'h0000000, st_q.month};
                `CCS_YEAR_OFS: st_d.prdata = {25'h0000000, st_q.year};
                `CCS_HOUR_OFS: st_d.prdata = {27'h0000000, st_q.hour};
                `CCS_MIN_OFS: st_d.prdata = {26'h0000000, st_q.minute};
                `CCS_SEC_OFS: st_d.prdata = {26'h0000000, st_q.sec};
                `CCS_WDAY_OFS: st_d.prdata = {29'h00000000, st_q.wday};
                `CCS_LIVE_OFS: st_d.prdata = {25'h0000000, st_q.live};
                `CCS_SYS_OFS: st_d.prdata = {29'h00000000, st_q.clockFail, 2'h0};
                `CCS_EVT_OFS: st_d.prdata = {24'h000000, st_q.evStat};
                `CCS_MASK_OFS: st_d.prdata = {24'h000000, st_q.mask};
                `CCS_STDATE_OFS: st_d.prdata = st_q.stageDate;
                `CCS_STTIME_OFS: st_d.prdata = st_q.stageTime;
                `CCS_CMD_OFS: st_d.prdata = 32'h00000000;
                default: st_d.pslverr = 1'b1;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************

    // calendar starts at day 1 month 1 year 0, Sunday, midnight
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '{tickCnt: 25'h0000000, day: `CCS_DAY_RST, month: `CCS_MONTH_RST, year: `CCS_YEAR_RST,
                      hour: `CCS_HOUR_RST, minute: `CCS_MIN_RST, sec: `CCS_SEC_RST, wday: `CCS_WDAY_RST,
                      live: 7'h00, clockFail: 1'b0, evStat: 8'h00, mask: `CCS_MASK_RST,
                      stageDate: 32'h00000000, stageTime: 32'h00000000, prdata: 32'h00000000,
                      pready: 1'b0, pslverr: 1'b0, irq: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign irq = st_q.irq;

    // ****************************************
    // assertions
    // ****************************************

    default clocking ccsCb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // a second tick at 59 wraps the second and pulses the minute bit
    sec_wrap_a: assert property (tick && !load && st_q.sec == 6'h3B && st_q.minute < 6'h3B
        |=> st_q.sec == 6'h00 && st_q.live[`CCS_MIN_CHG_BIT])
        else $error("second did not wrap into a minute change");

    // a minute change is seen at the same edge as its pulse
    minute_pulse_a: assert property ($changed(st_q.minute) |-> st_q.live[`CCS_MIN_CHG_BIT])
        else $error("minute changed without its pulse");

    hour_pulse_a: assert property ($changed(st_q.hour) |-> st_q.live[`CCS_HOUR_CHG_BIT])
        else $error("hour changed without its pulse");

    date_pulse_a: assert property ($changed(st_q.day) |-> st_q.live[`CCS_DATE_CHG_BIT])
        else $error("date changed without its pulse");

    month_pulse_a: assert property ($changed(st_q.month) |-> st_q.live[`CCS_MONTH_CHG_BIT])
        else $error("month changed without its pulse");

    year_pulse_a: assert property (st_q.live[`CCS_YEAR_CHG_BIT] |-> $changed(st_q.year))
        else $error("year pulse without a year change");

    // the change pulses never stretch past one cycle on their own
    pulse_once_a: assert property (st_q.live[`CCS_HOUR_CHG_BIT] && !load |=> !st_q.live[`CCS_HOUR_CHG_BIT])
        else $error("hour pulse lasted more than one cycle");

    battery_flag_a: assert property (batteryDead |=> st_q.live[`CCS_BATT_BIT])
        else $error("dead battery not flagged");

    invalid_flag_a: assert property (st_q.live[`CCS_INVALID_BIT] == !fieldsValid(st_q))
        else $error("invalid bit does not follow the fields");

    clock_fail_a: assert property (!oscRunning |=> st_q.clockFail
        ##1 (prdata[2] || !st_q.pready || paddr != `CCS_SYS_OFS))
        else $error("stopped clock not flagged");

    // a write to a time word leaves it untouched when no tick or load interferes
    ro_write_a: assert property (wrDone && paddr == `CCS_HOUR_OFS && !tick |=> $stable(st_q.hour))
        else $error("time word changed by an ordinary write");

    // on battery the seconds keep counting
    on_battery_a: assert property (!extPowerOk && !batteryDead && oscRunning && tick && !load
        && st_q.sec < 6'h3B |=> st_q.sec == $past(st_q.sec) + 6'h01)
        else $error("clock stopped without mains");

    weekday_wrap_a: assert property (tick && !load && st_q.wday == 3'h7 && st_q.sec == 6'h3B
        && st_q.minute == 6'h3B && st_q.hour == 5'h17 |=> st_q.wday == 3'h1)
        else $error("weekday did not wrap to Sunday");

    irq_level_a: assert property (st_q.irq == |(st_q.evStat & st_q.mask))
        else $error("interrupt does not follow masked status");

    // the other change pulses end after one cycle too
    min_once_a: assert property (st_q.live[`CCS_MIN_CHG_BIT] && !load |=> !st_q.live[`CCS_MIN_CHG_BIT])
        else $error("minute pulse lasted more than one cycle");

    date_once_a: assert property (st_q.live[`CCS_DATE_CHG_BIT] && !load |=> !st_q.live[`CCS_DATE_CHG_BIT])
        else $error("date pulse lasted more than one cycle");

    month_once_a: assert property (st_q.live[`CCS_MONTH_CHG_BIT] && !load |=> !st_q.live[`CCS_MONTH_CHG_BIT])
        else $error("month pulse lasted more than one cycle");

    year_once_a: assert property (st_q.live[`CCS_YEAR_CHG_BIT] && !load |=> !st_q.live[`CCS_YEAR_CHG_BIT])
        else $error("year pulse lasted more than one cycle");

    // the slave answers one cycle after setup and only for that cycle
    ready_setup_a: assert property (psel && !penable |=> st_q.pready)
        else $error("no answer after a setup cycle");

    ready_once_a: assert property (st_q.pready |=> !st_q.pready)
        else $error("ready stood longer than one cycle");

    err_ready_a: assert property (st_q.pslverr |-> st_q.pready)
        else $error("error response without ready");

    // the fail bit trails the fail condition by one cycle both ways
    fail_set_a: assert property (fail |=> st_q.clockFail)
        else $error("fail bit missed a stopped clock");

    fail_clear_a: assert property (!fail |=> !st_q.clockFail)
        else $error("fail bit stuck after recovery");

    // while failing, neither the divider nor the seconds move unless a load comes
    tick_hold_a: assert property (fail && !load |=> $stable(st_q.tickCnt))
        else $error("divider ran while the clock failed");

    sec_hold_a: assert property (fail && !load |=> $stable(st_q.sec))
        else $error("seconds ran while the clock failed");

    // a good battery keeps the clock going without mains
    battery_run_a: assert property (!extPowerOk && !batteryDead && oscRunning |=> !st_q.clockFail)
        else $error("clock failed on a good battery");

    // ordinary writes to other time words are ignored as well
    min_ro_a: assert property (wrDone && paddr == `CCS_MIN_OFS && !tick |=> $stable(st_q.minute))
        else $error("minute word changed by a write");

    day_ro_a: assert property (wrDone && paddr == `CCS_DAY_OFS && !tick |=> $stable(st_q.day))
        else $error("day word changed by a write");

    battery_clear_a: assert property (!batteryDead |=> !st_q.live[`CCS_BATT_BIT])
        else $error("battery bit set with a good battery");

    // status bits only fall through a read of the event word
    evt_sticky_a: assert property (!(rdDone && paddr == `CCS_EVT_OFS)
        |=> (st_q.evStat | $past(st_q.evStat)) == st_q.evStat)
        else $error("event bit lost without a read");

    // an out-of-range field always raises the invalid bit
    day_range_a: assert property (st_q.day < `CCS_DAY_MIN |-> st_q.live[`CCS_INVALID_BIT])
        else $error("day out of range not flagged");

    month_range_a: assert property (st_q.month < `CCS_MONTH_MIN || st_q.month > `CCS_MONTH_MAX
        |-> st_q.live[`CCS_INVALID_BIT])
        else $error("month out of range not flagged");

    year_range_a: assert property (st_q.year > `CCS_YEAR_MAX |-> st_q.live[`CCS_INVALID_BIT])
        else $error("year out of range not flagged");

    hour_range_a: assert property (st_q.hour > `CCS_HOUR_MAX |-> st_q.live[`CCS_INVALID_BIT])
        else $error("hour out of range not flagged");

    time_range_a: assert property (st_q.minute > `CCS_MIN_MAX || st_q.sec > `CCS_SEC_MAX
        |-> st_q.live[`CCS_INVALID_BIT])
        else $error("minute or second out of range not flagged");

    wday_range_a: assert property (st_q.wday < `CCS_WDAY_MIN |-> st_q.live[`CCS_INVALID_BIT])
        else $error("weekday out of range not flagged");

    // before the wrap the weekday steps by one at midnight
    weekday_step_a: assert property (tick && !load && st_q.wday < 3'h7 && st_q.sec == 6'h3B
        && st_q.minute == 6'h3B && st_q.hour == 5'h17 |=> st_q.wday == $past(st_q.wday) + 3'h1)
        else $error("weekday did not step at midnight");

endmodule : ccs_calendar_clock

/* File: src/ccs_defs.svh */
// offsets, field positions, reset values and timing counts of the calendar clock
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define CCS_ADDR_W 8
`define CCS_DAY_OFS 8'h00
`define CCS_MONTH_OFS 8'h04
`define CCS_YEAR_OFS 8'h08
`define CCS_HOUR_OFS 8'h0C
`define CCS_MIN_OFS 8'h10
`define CCS_SEC_OFS 8'h14
`define CCS_WDAY_OFS 8'h18
`define CCS_LIVE_OFS 8'h1C
`define CCS_SYS_OFS 8'h20
`define CCS_EVT_OFS 8'h24
`define CCS_MASK_OFS 8'h28
`define CCS_STDATE_OFS 8'h2C
`define CCS_STTIME_OFS 8'h30
`define CCS_CMD_OFS 8'h34

// ****************************************
// field positions
// ****************************************
`define CCS_MIN_CHG_BIT 0
`define CCS_HOUR_CHG_BIT 1
`define CCS_DATE_CHG_BIT 2
`define CCS_MONTH_CHG_BIT 3
`define CCS_YEAR_CHG_BIT 4
`define CCS_BATT_BIT 5
`define CCS_INVALID_BIT 6
`define CCS_CLK_FAIL_EV_BIT 7
`define CCS_SYS_CLK_FAIL_BIT 2
`define CCS_ST_DAY_LSB 0
`define CCS_ST_MONTH_LSB 8
`define CCS_ST_YEAR_LSB 16
`define CCS_ST_WDAY_LSB 24
`define CCS_ST_SEC_LSB 0
`define CCS_ST_MIN_LSB 8
`define CCS_ST_HOUR_LSB 16
`define CCS_CMD_LOAD_BIT 0

// ****************************************
// reset values and field limits
// ****************************************
`define CCS_DAY_RST 5'h01
`define CCS_MONTH_RST 4'h1
`define CCS_YEAR_RST 7'h00
`define CCS_HOUR_RST 5'h00
`define CCS_MIN_RST 6'h00
`define CCS_SEC_RST 6'h00
`define CCS_WDAY_RST 3'h1
`define CCS_MASK_RST 8'h00
`define CCS_SEC_MAX 6'h3B
`define CCS_MIN_MAX 6'h3B
`define CCS_HOUR_MAX 5'h17
`define CCS_DAY_MIN 5'h01
`define CCS_MONTH_MIN 4'h1
`define CCS_MONTH_MAX 4'hC
`define CCS_YEAR_MAX 7'h63
`define CCS_WDAY_MIN 3'h1
`define CCS_WDAY_MAX 3'h7

// ****************************************
// timing
// ****************************************
`define CCS_CLK_PERIOD_NS 40
`define CCS_SEC_NS 1000000000
`define CCS_TICK_CYCLES (`CCS_SEC_NS / `CCS_CLK_PERIOD_NS)

`endif

/* File: src/ccs_pkg.sv */
// types of the calendar clock
package ccs_pkg;
`include "ccs_defs.svh"

    typedef logic [31:0] ccs_word_t;
    typedef logic [`CCS_ADDR_W-1:0] ccs_addr_t;

    // whole state of the calendar clock block
    typedef struct packed {
        logic [24:0] tickCnt;
        logic [4:0] day;
        logic [3:0] month;
        logic [6:0] year;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] sec;
        logic [2:0] wday;
        logic [6:0] live;
        logic clockFail;
        logic [7:0] evStat;
        logic [7:0] mask;
        logic [31:0] stageDate;
        logic [31:0] stageTime;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } ccs_state_s;
endpackage : ccs_pkg

/* File: tb/tb_top.sv */
// self-checking bench of the calendar clock block, driven over its APB port
`timescale 1ns/1ns
`include "ccs_defs.svh"

module tb_top;
    import ccs_pkg::*;
    localparam int TPS = 64; // a short second keeps rollover runs brief
    logic clock;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    ccs_addr_t paddr;
    ccs_word_t pwdata;
    ccs_word_t prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic extPowerOk;
    logic batteryDead;
    logic oscRunning;
    int mismatches = 0;
    int checked = 0;
    ccs_word_t rdat;
    logic rerr;

    ccs_calendar_clock #(.TICKS_PER_SEC(TPS)) i_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .extPowerOk(extPowerOk),
        .batteryDead(batteryDead), .oscRunning(oscRunning));

    // free running 25 MHz clock
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string what, input ccs_word_t exp, input ccs_word_t got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic waitc(input int n);
        repeat (n) @(posedge clock);
    endtask : waitc

    // one APB transfer; only the watchdog ends the wait, and the answer must come in the first access cycle
    task automatic apb(input logic w, input ccs_addr_t a, input ccs_word_t d);
        int n;
        n = 0;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'h1);
        chk("ready delay", 32'h1, n);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask : apb

    task automatic rd(input ccs_addr_t a, input ccs_word_t exp, input string what);
        apb(1'h0, a, 32'h0);
        chk(what, exp, rdat);
    endtask : rd

    task automatic wr(input ccs_addr_t a, input ccs_word_t d);
        apb(1'h1, a, d);
    endtask : wr

    // stage date and time, then fire the set-calendar command
    task automatic load(input ccs_word_t dt, input ccs_word_t tm);
        wr(`CCS_STDATE_OFS, dt);
        wr(`CCS_STTIME_OFS, tm);
        wr(`CCS_CMD_OFS, 32'h1);
    endtask : load

    // two second reads exactly one tick apart
    task automatic secStep(input ccs_word_t inc);
        ccs_word_t s1;
        apb(1'h0, `CCS_SEC_OFS, 32'h0);
        s1 = rdat;
        waitc(TPS - 3);
        rd(`CCS_SEC_OFS, s1 + inc, "second step");
    endtask : secStep

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd(`CCS_DAY_OFS, 32'h01, "day");
        rd(`CCS_MONTH_OFS, 32'h01, "month");
        rd(`CCS_YEAR_OFS, 32'h00, "year");
        rd(`CCS_HOUR_OFS, 32'h00, "hour");
        rd(`CCS_MIN_OFS, 32'h00, "minute");
        rd(`CCS_SEC_OFS, 32'h00, "second");
        rd(`CCS_WDAY_OFS, 32'h01, "weekday");
        rd(`CCS_MASK_OFS, 32'h00, "mask");
        rd(`CCS_LIVE_OFS, 32'h00, "live");
        rd(`CCS_SYS_OFS, 32'h00, "system");
    endtask : t_reset

    task automatic t_access();
        wr(`CCS_DAY_OFS, 32'h05);
        rd(`CCS_DAY_OFS, 32'h01, "day after write");
        wr(`CCS_HOUR_OFS, 32'h0A);
        rd(`CCS_HOUR_OFS, 32'h00, "hour after write");
        wr(`CCS_MIN_OFS, 32'h07);
        rd(`CCS_MIN_OFS, 32'h00, "minute after write");
        apb(1'h0, 8'h3C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdat);
        wr(`CCS_MASK_OFS, 32'hFF);
        rd(`CCS_MASK_OFS, 32'hFF, "mask");
    endtask : t_access

    // 31 February is flagged, 28 February is not
    task automatic t_invalid();
        load(32'h0100_021F, 32'h0);
        rd(`CCS_LIVE_OFS, 32'h40, "invalid set");
        load(32'h0100_021C, 32'h0);
        rd(`CCS_LIVE_OFS, 32'h00, "invalid clear");
    endtask : t_invalid

    // new year's eve, Saturday 23:59:59, rolls over every field at once
    task automatic t_rollover();
        wr(`CCS_MASK_OFS, 32'h01);
        load(32'h0763_0C1F, 32'h0017_3B3B);
        apb(1'h0, `CCS_EVT_OFS, 32'h0);
        waitc(2);
        chk("irq idle", 32'h0, {31'h0, irq});
        waitc(70);
        chk("irq raised", 32'h1, {31'h0, irq});
        rd(`CCS_EVT_OFS, 32'h1F, "events");
        waitc(2);
        chk("irq after clear", 32'h0, {31'h0, irq});
        rd(`CCS_DAY_OFS, 32'h01, "day wrap");
        rd(`CCS_MONTH_OFS, 32'h01, "month wrap");
        rd(`CCS_YEAR_OFS, 32'h00, "year wrap");
        rd(`CCS_HOUR_OFS, 32'h00, "hour wrap");
        rd(`CCS_MIN_OFS, 32'h00, "minute wrap");
        rd(`CCS_SEC_OFS, 32'h00, "second wrap");
        rd(`CCS_WDAY_OFS, 32'h01, "weekday wrap");
        rd(`CCS_EVT_OFS, 32'h00, "events cleared");
    endtask : t_rollover

    // 00:00:59 carries into the minute alone
    task automatic t_minute();
        load(32'h0100_0101, 32'h0000_003B);
        waitc(70);
        rd(`CCS_MIN_OFS, 32'h01, "minute step");
        rd(`CCS_SEC_OFS, 32'h00, "second carry");
        rd(`CCS_HOUR_OFS, 32'h00, "hour kept");
        rd(`CCS_EVT_OFS, 32'h01, "minute event");
    endtask : t_minute

    task automatic t_power();
        wr(`CCS_MASK_OFS, 32'h00);
        batteryDead <= 1'h1;
        waitc(2);
        rd(`CCS_LIVE_OFS, 32'h20, "battery");
        secStep(32'h1);
        extPowerOk <= 1'h0;
        batteryDead <= 1'h0;
        secStep(32'h1);
        batteryDead <= 1'h1;
        waitc(3);
        rd(`CCS_SYS_OFS, 32'h04, "fail no power");
        secStep(32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        extPowerOk <= 1'h1;
        batteryDead <= 1'h0;
        oscRunning <= 1'h0;
        waitc(3);
        rd(`CCS_SYS_OFS, 32'h04, "fail no osc");
        oscRunning <= 1'h1;
        waitc(3);
        rd(`CCS_SYS_OFS, 32'h00, "fail gone");
        rd(`CCS_EVT_OFS, 32'hA0, "power events");
    endtask : t_power

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        reset_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        extPowerOk = 1'h1;
        batteryDead = 1'h0;
        oscRunning = 1'h1;
        waitc(12);
        reset_n <= 1'h1;
        waitc(1);
        t_reset();
        t_access();
        t_invalid();
        t_rollover();
        t_minute();
        t_power();
        end_of_test();
    end

    // the scenarios need well under 2000 cycles
    initial begin
        waitc(20000);
        mismatches++;
        end_of_test();
    end
endmodule : tb_top
